// ==== logic/sscr_ms_timer.sv ====
/*
 * sscr_ms_timer: counts a number of milliseconds after a start pulse.
 * Assumes aclk at the rate in sscr_pkg; start while busy restarts the count.
 */
`timescale 1ns/1ps
module sscr_ms_timer
    import sscr_pkg::*;
#(
    parameter int CYC_PER_MS = SSCR_CYC_PER_MS
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       start,
    input  wire logic [8:0] ms_count,
    output logic            done
);

    logic [17:0] cyc_ff;
    logic [8:0]  ms_ff;
    logic        busy_ff;
    logic        done_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc_ff  <= 18'h00000;
            ms_ff   <= 9'h000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (start)
            begin
                cyc_ff  <= 18'h00000;
                ms_ff   <= ms_count;
                busy_ff <= 1'b1;
            end
            else if (busy_ff)
            begin
                if (cyc_ff == 18'(CYC_PER_MS - 1))
                begin
                    cyc_ff <= 18'h00000;
                    if (ms_ff <= 9'h001)
                    begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end
                    else
                    begin
                        ms_ff <= ms_ff - 9'h001;
                    end
                end
                else
                begin
                    cyc_ff <= cyc_ff + 18'h00001;
                end
            end
        end
    end

    assign done = done_ff;

endmodule : sscr_ms_timer

// ==== logic/sscr_pkg.sv ====
/*
 * sscr_pkg: constants for the supply sequence configuration register bank.
 * Assumes a 250 MHz aclk; register indices are byte offsets divided by four.
 */
package sscr_pkg;

    // offsets are word indices; the byte address is four times the index
    localparam logic [7:0]  SSCR_IDX_OFS_CTRL  = 8'h10;
    localparam logic [7:0]  SSCR_IDX_BIAS_CTRL = 8'h11;
    localparam logic [7:0]  SSCR_IDX_AUX2_VOLT = 8'h14;
    localparam logic [7:0]  SSCR_IDX_SKIP_CTRL = 8'h16;
    localparam logic [7:0]  SSCR_IDX_USER_CFG  = 8'h17;
    localparam logic [7:0]  SSCR_IDX_SEQ_CTRL  = 8'h20;
    localparam logic [7:0]  SSCR_IDX_IRQ_STAT  = 8'h21;
    localparam logic [7:0]  SSCR_IDX_IRQ_MASK  = 8'h22;
    localparam int          SSCR_ADDR_W        = 10;

    localparam logic [7:0]  SSCR_RST_OFS_CTRL  = 8'hc0;
    localparam logic [7:0]  SSCR_RST_BIAS_CTRL = 8'h00;
    localparam logic [7:0]  SSCR_RST_AUX2_VOLT = 8'h00;
    localparam logic [7:0]  SSCR_RST_SKIP_CTRL = 8'h00;
    localparam logic [7:0]  SSCR_RST_USER_CFG  = 8'h02;

    localparam int          SSCR_TIME_LSB      = 5;
    localparam int          SSCR_CODE_MSB      = 4;
    localparam int          SSCR_SKIP_MSB      = 4;
    localparam logic [2:0]  SSCR_BIAS_BYPASS   = 3'h0;

    // 1 ms tick from the 250 MHz clock
    localparam int          SSCR_CLK_MHZ       = 250;
    localparam int          SSCR_MS_US         = 1000;
    localparam int          SSCR_CYC_PER_MS    = SSCR_CLK_MHZ * SSCR_MS_US;

    // sticky status bits
    localparam int          SSCR_IRQ_OFS_DONE  = 0;
    localparam int          SSCR_IRQ_BIAS_DONE = 1;
    localparam int          SSCR_IRQ_W         = 2;

    localparam logic [1:0]  SSCR_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  SSCR_RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0]
    {
        SSCR_ST_IDLE = 2'b00,
        SSCR_ST_OFS  = 2'b01,
        SSCR_ST_BIAS = 2'b11,
        SSCR_ST_DONE = 2'b10
    } sscr_state_t;

    // duration code to milliseconds
    function automatic logic [8:0] sscr_code_ms(input logic [2:0] code);
        logic [8:0] ms;
        ms = 9'h000;
        case (code)
            3'h0:    ms = 9'h001;
            3'h1:    ms = 9'h005;
            3'h2:    ms = 9'h00a;
            3'h3:    ms = 9'h014;
            3'h4:    ms = 9'h028;
            3'h5:    ms = 9'h050;
            3'h6:    ms = 9'h0a0;
            default: ms = 9'h140;
        endcase
        return ms;
    endfunction : sscr_code_ms

endpackage : sscr_pkg

// ==== logic/sscr_top.sv ====
/*
 * sscr_top: supply sequence configuration registers behind an AXI4-Lite slave,
 * with a small sequencing timer that applies the duration codes.
 * Assumes a single 250 MHz clock and a master that keeps one write and one read open.
 */
// Register access over AXI4-Lite was chosen for this implementation.
// How it works
// - offset-state time code in bits 7:5, codes map 1 to 320 ms, reset 110.
// - low-supply and undervoltage codes are separate 5-bit fields in bits 4:0.
// - bias-state time code in bits 7:5; code 000 bypasses the bias state.
// - bias/undervoltage register resets to zero and is read/write.
// - auxiliary converter 2 voltage is an 8-bit code.
// - auxiliary converter voltage register resets to zero, read/write.
// - five skip-mode enable bits, reset zero, one enables.
// - writes to skip register bits 7:5 have no effect.
// - user configuration register is read/write and resets to 02.
// - offset/low-supply register is read/write and resets to c0.
`timescale 1ns/1ps
module sscr_top
    import sscr_pkg::*;
#(
    parameter int CYC_PER_MS = SSCR_CYC_PER_MS
)
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [SSCR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [SSCR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [2:0]                  offset_state_time_code,
    output logic [4:0]                  low_supply_threshold_code,
    output logic [2:0]                  bias_state_time_code,
    output logic [4:0]                  undervoltage_threshold_code,
    output logic [7:0]                  aux2_converter_voltage_code,
    output logic                        aux3_converter_skip,
    output logic                        aux1_converter_skip,
    output logic                        aux2_converter_skip,
    output logic                        display_supply_converter_1_skip,
    output logic                        display_supply_converter_2_skip,
    output logic [7:0]                  user_configuration,
    output logic                        offset_supply_en,
    output logic                        bias_supply_en,
    output logic                        seq_done,
    output logic                        irq
);

    logic [7:0]              offset_time_and_low_supply_ctrl_ff;
    logic [7:0]              bias_time_and_undervoltage_ctrl_ff;
    logic [7:0]              aux2_converter_voltage_ff;
    logic [SSCR_SKIP_MSB:0]  converter_skip_ctrl_ff;
    logic [7:0]              user_configuration_ff;
    logic                    seq_start_ff;
    logic [SSCR_IRQ_W-1:0]   irq_stat_ff;
    logic [SSCR_IRQ_W-1:0]   irq_mask_ff;
    logic [SSCR_ADDR_W-1:0]  awaddr_ff;
    logic                    aw_held_ff;
    logic [31:0]             wdata_ff;
    logic [3:0]              wstrb_ff;
    logic                    w_held_ff;
    logic                    bvalid_ff;
    logic [1:0]              bresp_ff;
    logic                    rvalid_ff;
    logic [31:0]             rdata_ff;
    logic [1:0]              rresp_ff;
    sscr_state_t             state_ff;
    sscr_state_t             nxt_state;
    logic                    tmr_start;
    logic [8:0]              tmr_ms;
    logic                    tmr_done;
    logic                    wr_fire;
    logic [7:0]              wr_idx;
    logic                    wr_lane0;
    logic [SSCR_IRQ_W-1:0]   irq_set;
    logic [7:0]              rd_idx;
    logic [7:0]              rd_byte;
    logic                    rd_hit;

    // write channel: address and data latched independently, either order
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx        = awaddr_ff[SSCR_ADDR_W-1:2];
    assign wr_lane0      = wr_fire && wstrb_ff[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= SSCR_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= (wr_idx == SSCR_IDX_OFS_CTRL || wr_idx == SSCR_IDX_BIAS_CTRL ||
                               wr_idx == SSCR_IDX_AUX2_VOLT || wr_idx == SSCR_IDX_SKIP_CTRL ||
                               wr_idx == SSCR_IDX_USER_CFG || wr_idx == SSCR_IDX_SEQ_CTRL ||
                               wr_idx == SSCR_IDX_IRQ_STAT || wr_idx == SSCR_IDX_IRQ_MASK)
                              ? SSCR_RESP_OKAY : SSCR_RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // configuration registers; only byte lane 0 carries data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            offset_time_and_low_supply_ctrl_ff <= SSCR_RST_OFS_CTRL;
            bias_time_and_undervoltage_ctrl_ff <= SSCR_RST_BIAS_CTRL;
            aux2_converter_voltage_ff          <= SSCR_RST_AUX2_VOLT;
            converter_skip_ctrl_ff             <= SSCR_RST_SKIP_CTRL[SSCR_SKIP_MSB:0];
            user_configuration_ff              <= SSCR_RST_USER_CFG;
            irq_mask_ff                        <= '0;
        end
        else if (wr_lane0)
        begin
            case (wr_idx)
                SSCR_IDX_OFS_CTRL:  offset_time_and_low_supply_ctrl_ff <= wdata_ff[7:0];
                SSCR_IDX_BIAS_CTRL: bias_time_and_undervoltage_ctrl_ff <= wdata_ff[7:0];
                SSCR_IDX_AUX2_VOLT: aux2_converter_voltage_ff <= wdata_ff[7:0];
                SSCR_IDX_SKIP_CTRL: converter_skip_ctrl_ff <= wdata_ff[SSCR_SKIP_MSB:0];
                SSCR_IDX_USER_CFG:  user_configuration_ff <= wdata_ff[7:0];
                SSCR_IDX_IRQ_MASK:  irq_mask_ff <= wdata_ff[SSCR_IRQ_W-1:0];
                default:            irq_mask_ff <= irq_mask_ff;
            endcase
        end
    end

    // start is a self-clearing command bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            seq_start_ff <= 1'b0;
        else
            seq_start_ff <= wr_lane0 && wr_idx == SSCR_IDX_SEQ_CTRL && wdata_ff[0];
    end

    // sticky status; a new event wins over a write-one clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_ff <= '0;
        else if (wr_lane0 && wr_idx == SSCR_IDX_IRQ_STAT)
            irq_stat_ff <= (irq_stat_ff & ~wdata_ff[SSCR_IRQ_W-1:0]) | irq_set;
        else
            irq_stat_ff <= irq_stat_ff | irq_set;
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // field views
    assign offset_state_time_code          = offset_time_and_low_supply_ctrl_ff[7:SSCR_TIME_LSB];
    assign low_supply_threshold_code       = offset_time_and_low_supply_ctrl_ff[SSCR_CODE_MSB:0];
    assign bias_state_time_code            = bias_time_and_undervoltage_ctrl_ff[7:SSCR_TIME_LSB];
    assign undervoltage_threshold_code     = bias_time_and_undervoltage_ctrl_ff[SSCR_CODE_MSB:0];
    assign aux2_converter_voltage_code     = aux2_converter_voltage_ff;
    assign aux3_converter_skip             = converter_skip_ctrl_ff[4];
    assign aux1_converter_skip             = converter_skip_ctrl_ff[3];
    assign aux2_converter_skip             = converter_skip_ctrl_ff[2];
    assign display_supply_converter_1_skip = converter_skip_ctrl_ff[1];
    assign display_supply_converter_2_skip = converter_skip_ctrl_ff[0];
    assign user_configuration              = user_configuration_ff;

    // sequencer: offset state, then bias state unless bypassed
    always_comb
    begin
        nxt_state = state_ff;
        tmr_start = 1'b0;
        tmr_ms    = sscr_code_ms(offset_state_time_code);
        irq_set   = '0;
        case (state_ff)
            SSCR_ST_IDLE, SSCR_ST_DONE:
            begin
                if (seq_start_ff)
                begin
                    nxt_state = SSCR_ST_OFS;
                    tmr_start = 1'b1;
                end
            end
            SSCR_ST_OFS:
            begin
                if (tmr_done)
                begin
                    irq_set[SSCR_IRQ_OFS_DONE] = 1'b1;
                    if (bias_state_time_code == SSCR_BIAS_BYPASS)
                    begin
                        nxt_state = SSCR_ST_DONE;
                    end
                    else
                    begin
                        nxt_state = SSCR_ST_BIAS;
                        tmr_start = 1'b1;
                        tmr_ms    = sscr_code_ms(bias_state_time_code);
                    end
                end
            end
            SSCR_ST_BIAS:
            begin
                if (tmr_done)
                begin
                    irq_set[SSCR_IRQ_BIAS_DONE] = 1'b1;
                    nxt_state = SSCR_ST_DONE;
                end
            end
            default: nxt_state = SSCR_ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_ff <= SSCR_ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    sscr_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (tmr_start),
        .ms_count (tmr_ms),
        .done     (tmr_done)
    );

    assign offset_supply_en = state_ff != SSCR_ST_IDLE;
    assign bias_supply_en   = state_ff == SSCR_ST_BIAS || state_ff == SSCR_ST_DONE;
    assign seq_done         = state_ff == SSCR_ST_DONE;

    // read channel: one cycle from address to data
    assign s_axi_arready = !rvalid_ff;
    assign rd_idx        = s_axi_araddr[SSCR_ADDR_W-1:2];

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (rd_idx)
            SSCR_IDX_OFS_CTRL:  rd_byte = offset_time_and_low_supply_ctrl_ff;
            SSCR_IDX_BIAS_CTRL: rd_byte = bias_time_and_undervoltage_ctrl_ff;
            SSCR_IDX_AUX2_VOLT: rd_byte = aux2_converter_voltage_ff;
            SSCR_IDX_SKIP_CTRL: rd_byte = {3'h0, converter_skip_ctrl_ff};
            SSCR_IDX_USER_CFG:  rd_byte = user_configuration_ff;
            SSCR_IDX_SEQ_CTRL:  rd_byte = {6'h00, state_ff};
            SSCR_IDX_IRQ_STAT:  rd_byte = {6'h00, irq_stat_ff};
            SSCR_IDX_IRQ_MASK:  rd_byte = {6'h00, irq_mask_ff};
            default:            rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= SSCR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h000000, rd_byte};
            rresp_ff  <= rd_hit ? SSCR_RESP_OKAY : SSCR_RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // bypass must skip the bias state within one edge of the offset timer ending
    bias_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == SSCR_ST_OFS && tmr_done && bias_state_time_code == SSCR_BIAS_BYPASS
        |=> state_ff == SSCR_ST_DONE && !$past(bias_supply_en))
        else $error("bias state not bypassed");

    bias_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == SSCR_ST_OFS && tmr_done && bias_state_time_code != SSCR_BIAS_BYPASS
        |=> state_ff == SSCR_ST_BIAS)
        else $error("bias state not entered");

    seq_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_ff == SSCR_ST_OFS && !tmr_done |=> state_ff == SSCR_ST_OFS)
        else $error("offset state left before time elapsed");

    sequence skip_write_s;
        wr_lane0 && wr_idx == SSCR_IDX_SKIP_CTRL;
    endsequence

    skip_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        skip_write_s |=> converter_skip_ctrl_ff == $past(wdata_ff[SSCR_SKIP_MSB:0]))
        else $error("skip bits not written");

    skip_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_idx == SSCR_IDX_SKIP_CTRL
        |=> s_axi_rdata[31:SSCR_SKIP_MSB+1] == '0)
        else $error("skip reserved bits read back set");

    reset_ofs_a: assert property (@(posedge aclk)
        !aresetn |=> offset_time_and_low_supply_ctrl_ff == SSCR_RST_OFS_CTRL && offset_state_time_code == 3'h6)
        else $error("offset register reset value wrong");

    reset_bias_a: assert property (@(posedge aclk)
        !aresetn |=> bias_time_and_undervoltage_ctrl_ff == SSCR_RST_BIAS_CTRL)
        else $error("bias register reset value wrong");

    reset_aux_a: assert property (@(posedge aclk)
        !aresetn |=> aux2_converter_voltage_code == SSCR_RST_AUX2_VOLT && converter_skip_ctrl_ff == '0)
        else $error("converter registers reset wrong");

    reset_user_a: assert property (@(posedge aclk)
        !aresetn |=> user_configuration == SSCR_RST_USER_CFG)
        else $error("user configuration reset wrong");

    aux_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && wr_idx == SSCR_IDX_AUX2_VOLT |=> aux2_converter_voltage_code == $past(wdata_ff[7:0]))
        else $error("aux voltage code not written");

    field_split_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && wr_idx == SSCR_IDX_OFS_CTRL
        |=> low_supply_threshold_code == $past(wdata_ff[4:0]) && offset_state_time_code == $past(wdata_ff[7:5]))
        else $error("offset register fields wrong");

endmodule : sscr_top

// ==== sim/testbench.sv ====
/*
 * testbench: self-checking bench for sscr_top, registers reached over AXI4-Lite.
 * Assumes sscr_pkg and sscr_top are compiled first; CYC_PER_MS is cut to 4 to keep runs short.
 */
`timescale 1ns/1ps
module testbench
    import sscr_pkg::*;
;
    logic                   aclk          = 1'b0;
    logic                   aresetn       = 1'b0;
    logic [SSCR_ADDR_W-1:0] s_axi_awaddr  = '0;
    logic [SSCR_ADDR_W-1:0] s_axi_araddr  = '0;
    logic [31:0]            s_axi_wdata   = '0;
    logic [3:0]             s_axi_wstrb   = 4'hf;
    logic                   s_axi_awvalid = 1'b0;
    logic                   s_axi_wvalid  = 1'b0;
    logic                   s_axi_bready  = 1'b0;
    logic                   s_axi_arvalid = 1'b0;
    logic                   s_axi_rready  = 1'b0;
    logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]             s_axi_bresp, s_axi_rresp;
    logic [31:0]            s_axi_rdata;
    logic [2:0]             offset_state_time_code, bias_state_time_code;
    logic [4:0]             low_supply_threshold_code, undervoltage_threshold_code;
    logic [7:0]             aux2_converter_voltage_code, user_configuration;
    logic                   aux3_converter_skip, aux1_converter_skip, aux2_converter_skip;
    logic                   display_supply_converter_1_skip, display_supply_converter_2_skip;
    logic                   offset_supply_en, bias_supply_en, seq_done, irq;
    int                     error_cnt = 0;
    int                     n_checks  = 0;
    int                     cnt;
    logic [31:0]            lfsr      = 32'h21fdee93;
    logic [1:0]             r;
    logic [7:0]             v;
    int                     k;
    logic [7:0]             idx [5]   = '{8'h10, 8'h11, 8'h14, 8'h16, 8'h17};
    logic [7:0]             m [5]     = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h02};

    sscr_top #(.CYC_PER_MS(4)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .offset_state_time_code, .low_supply_threshold_code, .bias_state_time_code, .undervoltage_threshold_code,
        .aux2_converter_voltage_code, .aux3_converter_skip, .aux1_converter_skip, .aux2_converter_skip,
        .display_supply_converter_1_skip, .display_supply_converter_2_skip, .user_configuration,
        .offset_supply_en, .bias_supply_en, .seq_done, .irq);

    initial
    begin
        forever #2 aclk = ~aclk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    // skip register keeps only its five enables
    function automatic logic [31:0] exp_rd(input int i, input logic [7:0] d);
        return (i == 3) ? {27'h0, d[4:0]} : {24'h0, d};
    endfunction : exp_rd

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    // upper data bytes are random junk the slave must drop
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= {lfsr[23:0], d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata === e && s_axi_rresp === er, "read data or response wrong");
        s_axi_rready <= 1'b0;
    endtask : rd_chk

    task automatic fld_chk();
        chk({offset_state_time_code, low_supply_threshold_code} === m[0], "offset field");
        chk({bias_state_time_code, undervoltage_threshold_code} === m[1], "bias field");
        chk(aux2_converter_voltage_code === m[2], "aux2 voltage");
        chk({aux3_converter_skip, aux1_converter_skip, aux2_converter_skip, display_supply_converter_1_skip,
             display_supply_converter_2_skip} === m[3][4:0], "skip enables");
        chk(user_configuration === m[4], "user configuration");
    endtask : fld_chk

    task automatic run_seq(input int lo, input int hi);
        wr(SSCR_IDX_SEQ_CTRL, 8'h01, r);
        cnt = 0;
        // a rerun starts from done, which clears on the same edge that the write returns on
        do
        begin
            @(posedge aclk);
            cnt++;
            if (cnt == 2)
                chk(offset_supply_en === 1'b1 && bias_supply_en === 1'b0, "offset state outputs");
        end
        while (seq_done !== 1'b1 && cnt < 100);
        chk(cnt >= lo && cnt <= hi, "sequence duration");
        chk(offset_supply_en === 1'b1 && bias_supply_en === 1'b1, "done state outputs");
    endtask : run_seq

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk(idx[i], exp_rd(i, m[i]), SSCR_RESP_OKAY);
        fld_chk();
        // first ten passes are the all-ones and all-zeros corners
        for (int n = 0; n < 40; n++)
        begin
            k = (n < 10) ? n % 5 : int'(lfsr[15:0]) % 5;
            v = (n < 5) ? 8'hff : ((n < 10) ? 8'h00 : lfsr[31:24]);
            lfsr = nxt(lfsr);
            wr(idx[k], v, r);
            chk(r === SSCR_RESP_OKAY, "write response");
            m[k] = v;
            rd_chk(idx[k], exp_rd(k, v), SSCR_RESP_OKAY);
            fld_chk();
        end
        wr(8'h12, 8'h5a, r);
        chk(r === SSCR_RESP_SLVERR, "unmapped write accepted");
        rd_chk(8'h12, 32'h0, SSCR_RESP_SLVERR);
        fld_chk();
        // lane 0 strobe low: the register must keep its value
        s_axi_wstrb <= 4'he;
        wr(idx[4], ~m[4], r);
        s_axi_wstrb <= 4'hf;
        rd_chk(idx[4], exp_rd(4, m[4]), SSCR_RESP_OKAY);
        m[0] = 8'h00;
        m[1] = 8'h20;
        wr(idx[0], m[0], r);
        wr(idx[1], m[1], r);
        wr(SSCR_IDX_IRQ_MASK, 8'h00, r);
        run_seq(22, 34);
        chk(irq === 1'b0, "masked event raised irq");
        rd_chk(SSCR_IDX_IRQ_STAT, 32'h3, SSCR_RESP_OKAY);
        wr(SSCR_IDX_IRQ_MASK, 8'h03, r);
        chk(irq === 1'b1, "unmasked event gave no irq");
        wr(SSCR_IDX_IRQ_STAT, 8'h03, r);
        chk(irq === 1'b0, "irq stuck after clear");
        m[1] = 8'h00;
        wr(idx[1], m[1], r);
        run_seq(2, 12);
        fld_chk();
        results();
    end
endmodule : testbench
